// ### cns_defines.vh
// Purpose: Shared constants for the contact number selector
// Assumes: Included by the group and selector design files and the checks
// Notes:   Definitions only
`ifndef CNS_DEFINES_VH
`define CNS_DEFINES_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define CNS_ADDR_W          4
`define CNS_OFF_CFG         4'h0
`define CNS_OFF_ASSIGN      4'h1
`define CNS_OFF_PATTERN     4'h2
`define CNS_OFF_PID         4'h3
`define CNS_OFF_PRESET      4'h4
`define CNS_OFF_LOCKS       4'h5

// ---------------------------------------------------------------
// Field positions in the config register
// ---------------------------------------------------------------
`define CNS_CFG_PAT_METHOD  0
`define CNS_CFG_PID_METHOD  1
`define CNS_CFG_PRE_METHOD  2
`define CNS_CFG_ZONE_LO     4
`define CNS_CFG_ZONE_HI     6

// ---------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------
`define CNS_CFG_RESET       8'h00
`define CNS_ASSIGN_RESET    9'h1ff
`define CNS_NUM_RESET       3'h1
`define CNS_ZONE_LOCAL_PID  3'h5
`define CNS_METHOD_SW1      1'b0
`define CNS_METHOD_SW2      1'b1
`define CNS_MAX_PATTERN     3'h4
`define CNS_MAX_PID         3'h4
`define CNS_MAX_PRESET      3'h5

`endif

// ### cns_reset_sync.v
// Purpose: Two-stage release of the active-low reset
// Assumes: rst_n may drop at any time
// Notes:   Assert is asynchronous, release is on sys_clk
`timescale 1ns/1ps
module cns_reset_sync
(
  input  wire sys_clk,
  input  wire rst_n,
  output wire rst_sync_n
);

  reg stage1;
  reg stage2;

  // Only the second stage is seen by the rest of the design
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end
    else
    begin
      stage1 <= 1'b1;
      stage2 <= stage1;
    end
  end

  assign rst_sync_n = stage2;

endmodule

// ### cns_group.v
// Purpose: One selector group: contacts plus software to a number
// Assumes: Contacts already masked by assignment
// Notes:   Number held in a register, 1-based
`timescale 1ns/1ps
`include "cns_defines.vh"
module cns_group
#(
  parameter [2:0] MAX_NUM = 3'h4
)
(
  input  wire       sys_clk,
  input  wire       rst_sync_n,
  input  wire [2:0] contacts,
  input  wire       method,
  input  wire       sw_req,
  input  wire [2:0] sw_num,
  output reg  [2:0] number,
  output wire       sw_locked,
  output wire       sw_reject
);

  wire       all_off;
  wire [3:0] code_plus1;
  reg  [2:0] next_number;

  assign all_off    = (contacts == 3'h0);
  assign code_plus1 = {1'b0, contacts} + 4'h1;

  // Software is locked whenever a contact is on, or always in method 2
  assign sw_locked = (method == `CNS_METHOD_SW2) || !all_off;
  assign sw_reject = sw_req && sw_locked;

  // Next number; invalid codes keep the previous value
  always @*
  begin
    next_number = number;
    if (method == `CNS_METHOD_SW1)
    begin
      if (!all_off)
      begin
        if (contacts <= MAX_NUM)
          next_number = contacts;
      end
      else if (sw_req && sw_num != 3'h0 && sw_num <= MAX_NUM)
        next_number = sw_num;
    end
    else
    begin
      if (code_plus1 <= {1'b0, MAX_NUM})
        next_number = code_plus1[2:0];
    end
  end

  // Number register
  always @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      number <= `CNS_NUM_RESET;
    else
      number <= next_number;
  end

endmodule

// ### cns_selector.v
// Purpose: Contact number selector for pattern, PID and preset groups
// Assumes: Contact inputs synchronous to sys_clk, 1 means contact on
// Notes:   Registers over a plain strobe port, read data one cycle on
//
// How it works
// - Method 1: pattern number is the contact code, 001 to 100.
// - Method 2: pattern number is contact code plus one.
// - Pattern method bit: 0 picks method 1, 1 picks method 2.
// - Method 1: software pattern change only while all contacts off.
// - Method 1: all pattern contacts off keeps the previous pattern.
// - Method 2: software changes always refused, contacts decide.
// - Unassigned selector bits read as off.
// - Contact on reads as 1, off as 0.
// - Method 1: PID number is the contact code, 001 to 100.
// - Method 2: PID number is contact code plus one.
// - Method 1: software PID change only while all contacts off.
// - PID method bit: 0 picks method 1, else method 2.
// - Zone set to local PID: local choice used, contacts update it.
// - Method 1: preset number is the contact code, 001 to 101.
// - Method 2: preset number is contact code plus one.
// - Method 1: software preset change only while all contacts off.
// - Preset method bit: 0 picks method 1, 1 picks method 2.
`timescale 1ns/1ps
`include "cns_defines.vh"
module cns_selector
(
  input  wire                    sys_clk,
  input  wire                    rst_n,
  input  wire                    pattern_sel_bit0,
  input  wire                    pattern_sel_bit1,
  input  wire                    pattern_sel_bit2,
  input  wire                    pid_sel_bit0,
  input  wire                    pid_sel_bit1,
  input  wire                    pid_sel_bit2,
  input  wire                    preset_sel_bit0,
  input  wire                    preset_sel_bit1,
  input  wire                    preset_sel_bit2,
  input  wire [`CNS_ADDR_W-1:0]  reg_addr,
  input  wire [7:0]              reg_wdata,
  input  wire                    reg_write,
  input  wire                    reg_read,
  output reg  [7:0]              reg_rdata,
  output wire [2:0]              pattern_number,
  output wire [2:0]              pid_number,
  output wire [2:0]              preset_number,
  output wire [2:0]              local_pid_choice,
  output wire                    sw_reject
);

  // -------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------
  wire rst_sync_n;

  cns_reset_sync u_rst
  (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .rst_sync_n (rst_sync_n)
  );

  // -------------------------------------------------------------
  // Configuration registers
  // -------------------------------------------------------------
  reg  [7:0] cfg;
  reg  [8:0] assign_map;
  wire       pattern_method_cfg;
  wire       pid_method_cfg;
  wire       preset_method_cfg;
  wire [2:0] zone_select_cfg;
  wire       wr_cfg;
  wire       wr_assign;

  assign wr_cfg    = reg_write && (reg_addr == `CNS_OFF_CFG);
  assign wr_assign = reg_write && (reg_addr == `CNS_OFF_ASSIGN);

  // Single bits pick the encoding per group
  assign pattern_method_cfg = cfg[`CNS_CFG_PAT_METHOD];
  assign pid_method_cfg     = cfg[`CNS_CFG_PID_METHOD];
  assign preset_method_cfg  = cfg[`CNS_CFG_PRE_METHOD];
  assign zone_select_cfg    = cfg[`CNS_CFG_ZONE_HI:`CNS_CFG_ZONE_LO];

  // Config writes; bit 3 and 7 reserved, stored as zero
  always @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cfg        <= `CNS_CFG_RESET;
      assign_map <= `CNS_ASSIGN_RESET;
    end
    else
    begin
      if (wr_cfg)
        cfg <= reg_wdata & 8'h77;
      if (wr_assign)
        assign_map <= {reg_wdata[0], reg_wdata};
    end
  end

  // -------------------------------------------------------------
  // Contact masking
  // -------------------------------------------------------------
  // The assign register has 8 bits; bit 8 (preset bit2) copies
  // bit 0 on every assign write, with no mirror of its own, kept simple here.
  wire [8:0] raw_contacts;
  wire [8:0] contacts;

  // Contact on is 1, unassigned bits forced off
  assign raw_contacts = {preset_sel_bit2, preset_sel_bit1,
                         preset_sel_bit0, pid_sel_bit2, pid_sel_bit1,
                         pid_sel_bit0, pattern_sel_bit2,
                         pattern_sel_bit1, pattern_sel_bit0};
  assign contacts = raw_contacts & assign_map;

  // -------------------------------------------------------------
  // Software requests
  // -------------------------------------------------------------
  wire wr_pattern;
  wire wr_pid;
  wire wr_preset;

  assign wr_pattern = reg_write && (reg_addr == `CNS_OFF_PATTERN);
  assign wr_pid     = reg_write && (reg_addr == `CNS_OFF_PID);
  assign wr_preset  = reg_write && (reg_addr == `CNS_OFF_PRESET);

  // -------------------------------------------------------------
  // Groups
  // -------------------------------------------------------------
  wire lock_pattern;
  wire lock_pid;
  wire lock_preset;
  wire rej_pattern;
  wire rej_pid;
  wire rej_preset;

  cns_group #(.MAX_NUM(`CNS_MAX_PATTERN)) u_pattern
  (
    .sys_clk    (sys_clk),
    .rst_sync_n (rst_sync_n),
    .contacts   (contacts[2:0]),
    .method     (pattern_method_cfg),
    .sw_req     (wr_pattern),
    .sw_num     (reg_wdata[2:0]),
    .number     (pattern_number),
    .sw_locked  (lock_pattern),
    .sw_reject  (rej_pattern)
  );

  cns_group #(.MAX_NUM(`CNS_MAX_PID)) u_pid
  (
    .sys_clk    (sys_clk),
    .rst_sync_n (rst_sync_n),
    .contacts   (contacts[5:3]),
    .method     (pid_method_cfg),
    .sw_req     (wr_pid),
    .sw_num     (reg_wdata[2:0]),
    .number     (local_pid_choice),
    .sw_locked  (lock_pid),
    .sw_reject  (rej_pid)
  );

  cns_group #(.MAX_NUM(`CNS_MAX_PRESET)) u_preset
  (
    .sys_clk    (sys_clk),
    .rst_sync_n (rst_sync_n),
    .contacts   (contacts[8:6]),
    .method     (preset_method_cfg),
    .sw_req     (wr_preset),
    .sw_num     (reg_wdata[2:0]),
    .number     (preset_number),
    .sw_locked  (lock_preset),
    .sw_reject  (rej_preset)
  );

  // -------------------------------------------------------------
  // PID group in use
  // -------------------------------------------------------------
  // Outside local-PID zone the controller's zone logic picks the
  // group; this block then reports zero so nothing stale is used.
  assign pid_number = (zone_select_cfg == `CNS_ZONE_LOCAL_PID) ?
                      local_pid_choice : 3'h0;

  assign sw_reject = rej_pattern | rej_pid | rej_preset;

  // -------------------------------------------------------------
  // Read port
  // -------------------------------------------------------------
  // Data stand only in the cycle after the read strobe
  always @(posedge sys_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      case (reg_addr)
        `CNS_OFF_CFG:     reg_rdata <= cfg;
        `CNS_OFF_ASSIGN:  reg_rdata <= assign_map[7:0];
        `CNS_OFF_PATTERN: reg_rdata <= {5'h00, pattern_number};
        `CNS_OFF_PID:     reg_rdata <= {5'h00, local_pid_choice};
        `CNS_OFF_PRESET:  reg_rdata <= {5'h00, preset_number};
        `CNS_OFF_LOCKS:   reg_rdata <= {5'h00, lock_preset, lock_pid,
                                        lock_pattern};
        default:          reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule

// ### cns_selector_assertions.sv
// Purpose: Port checks for the contact number selector
// Assumes: Contact masks shadowed the same way as the design
// Notes:   Config and mask writes are shadowed from the port
`timescale 1ns/1ps
`include "cns_defines.vh"
module cns_sel_chk
(
  input wire       sys_clk,
  input wire       rst_n,
  input wire       pattern_sel_bit0, pattern_sel_bit1, pattern_sel_bit2,
  input wire       pid_sel_bit0, pid_sel_bit1, pid_sel_bit2,
  input wire       preset_sel_bit0, preset_sel_bit1, preset_sel_bit2,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_write,
  input wire       reg_read,
  input wire [7:0] reg_rdata,
  input wire [2:0] pattern_number,
  input wire [2:0] pid_number,
  input wire [2:0] preset_number,
  input wire [2:0] local_pid_choice,
  input wire       sw_reject
);
  reg  [2:0] up;
  reg  [7:0] cfg;
  reg  [7:0] asg;
  wire [2:0] pc = {pattern_sel_bit2, pattern_sel_bit1, pattern_sel_bit0};
  wire [2:0] pm = pc & asg[2:0];
  // Masked like the design: preset bit 2 follows the bit 0 mask
  wire [2:0] dc = {pid_sel_bit2, pid_sel_bit1, pid_sel_bit0} & asg[5:3];
  wire [2:0] rc = {preset_sel_bit2, preset_sel_bit1, preset_sel_bit0}
                  & {asg[0], asg[7:6]};
  wire       w2 = reg_write && reg_addr == `CNS_OFF_PATTERN;

  // ------------------------------------------------------------
  // Shadow state
  // ------------------------------------------------------------
  // Three stages: the design itself waits two edges after release
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up  <= 3'h0;
      cfg <= `CNS_CFG_RESET;
      asg <= 8'hff;
    end
    else
    begin
      up <= {up[1:0], 1'b1};
      if (reg_write && reg_addr == `CNS_OFF_CFG)
        cfg <= reg_wdata;
      if (reg_write && reg_addr == `CNS_OFF_ASSIGN)
        asg <= reg_wdata;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!up[2]);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence sw_take;
    w2 && !cfg[0] && pm == 3'h0 && reg_wdata[2:0] != 3'h0
      && reg_wdata[7:0] <= 8'h04;
  endsequence

  pat_m1_map_a: assert property (!cfg[0] && pm != 0 && pm <= 3'h4
    |=> pattern_number == $past(pm)) else $error("pattern code map");
  pat_m2_map_a: assert property (cfg[0] && pm <= 3'h3
    |=> pattern_number == $past(pm) + 3'h1) else $error("pattern m2 map");
  pat_hold_a: assert property (!cfg[0] && (pm == 0 || pm > 3'h4) && !w2
    |=> $stable(pattern_number)) else $error("pattern not held");
  sw_take_a: assert property (sw_take
    |=> pattern_number == $past(reg_wdata[2:0])) else $error("sw write lost");
  sw_lock_a: assert property (reg_write && (
    (w2 && (cfg[0] || pm != 0)) ||
    (reg_addr == `CNS_OFF_PID && (cfg[1] || dc != 0)) ||
    (reg_addr == `CNS_OFF_PRESET && (cfg[2] || rc != 0))) |-> sw_reject)
    else $error("sw write not refused");
  pid_route_a: assert property (pid_number ==
    ((cfg[6:4] == `CNS_ZONE_LOCAL_PID) ? local_pid_choice : 3'h0))
    else $error("pid route");
  pid_m1_map_a: assert property (!cfg[1] && dc != 0 && dc <= 3'h4
    |=> local_pid_choice == $past(dc)) else $error("pid m1 map");
  pid_m2_map_a: assert property (cfg[1] && dc <= 3'h3
    |=> local_pid_choice == $past(dc) + 3'h1) else $error("pid m2 map");
  pre_m1_map_a: assert property (!cfg[2] && rc != 0 && rc <= 3'h5
    |=> preset_number == $past(rc)) else $error("preset m1 map");
  pre_m2_map_a: assert property (cfg[2] && rc <= 3'h4
    |=> preset_number == $past(rc) + 3'h1) else $error("preset m2 map");
endmodule

bind cns_selector cns_sel_chk cns_sel_chk_inst (.*);

// ### cns_contacts.sv
// Purpose: Model of the external selector contacts
// Assumes: Codes set by the bench, one bit per contact
// Notes:   Closed contact reads 1
`timescale 1ns/1ps
module cns_contacts
(
  input wire       sys_clk,
  input wire [2:0] pat_code,
  input wire [2:0] pid_code,
  input wire [2:0] pre_code,
  output reg       pattern_sel_bit0, pattern_sel_bit1, pattern_sel_bit2,
  output reg       pid_sel_bit0, pid_sel_bit1, pid_sel_bit2,
  output reg       preset_sel_bit0, preset_sel_bit1, preset_sel_bit2
);
  // Switches settle one edge after the code changes
  always @(posedge sys_clk)
  begin
    {pattern_sel_bit2, pattern_sel_bit1, pattern_sel_bit0} <= pat_code;
    {pid_sel_bit2, pid_sel_bit1, pid_sel_bit0} <= pid_code;
    {preset_sel_bit2, preset_sel_bit1, preset_sel_bit0} <= pre_code;
  end
endmodule

// ### cns_selector_tb.sv
// Purpose: Self-checking bench for the contact number selector
// Assumes: Contacts driven through the contact model
// Notes:   Register writes are spaced one idle cycle apart
`timescale 1ns/1ps
module cns_selector_tb;
  reg        sys_clk = 1'b0;
  reg        rst_n = 1'b0;
  reg  [3:0] reg_addr = 4'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_write = 1'b0;
  reg        reg_read = 1'b0;
  reg  [2:0] pat_code = 3'h0, pid_code = 3'h0, pre_code = 3'h0;
  reg        rej;
  wire       pattern_sel_bit0, pattern_sel_bit1, pattern_sel_bit2;
  wire       pid_sel_bit0, pid_sel_bit1, pid_sel_bit2;
  wire       preset_sel_bit0, preset_sel_bit1, preset_sel_bit2;
  wire [7:0] reg_rdata;
  wire [2:0] pattern_number, pid_number, preset_number, local_pid_choice;
  wire       sw_reject;
  integer    err_count = 0;
  integer    check_count = 0;
  integer    i;
  reg  [7:0] rdv;

  cns_contacts cns_contacts_inst (.*);
  cns_selector cns_selector_inst (.*);

  // Clock of 25 ns
  always #12.5 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input [7:0] got, input [7:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task nums(input [2:0] p, input [2:0] d, input [2:0] r);
  begin
    chk({5'h0, pattern_number}, {5'h0, p});
    chk({5'h0, local_pid_choice}, {5'h0, d});
    chk({5'h0, preset_number}, {5'h0, r});
  end
  endtask
  // Idle cycle after each write keeps strobes one cycle long
  task wr(input [3:0] a, input [7:0] d);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(negedge sys_clk);
    rej = sw_reject;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    @(negedge sys_clk);
  end
  endtask
  task pc(input [2:0] p, input [2:0] d, input [2:0] r);
  begin
    @(posedge sys_clk);
    pat_code <= p;
    pid_code <= d;
    pre_code <= r;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  end
  endtask
  // Read strobe one cycle; data stand only in the cycle after it
  task rd(input [3:0] a, output [7:0] d);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  end
  endtask
  task close_out;
  begin
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  // Watchdog, well beyond the roughly 130 cycles of the tests
  initial
  begin
    #200000;
    err_count = err_count + 1;
    close_out;
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge sys_clk);
    nums(3'h1, 3'h1, 3'h1);
    chk({5'h0, pid_number}, 8'h00);
    rd(4'h0, rdv);
    chk(rdv, 8'h00);
    $display("test reset done");
    for (i = 1; i < 8; i = i + 1)
    begin
      pc(i[2:0], i[2:0], i[2:0]);
      nums((i > 4) ? 3'h4 : i[2:0], (i > 4) ? 3'h4 : i[2:0],
           (i > 5) ? 3'h5 : i[2:0]);
    end
    pc(3'h0, 3'h0, 3'h0);
    nums(3'h4, 3'h4, 3'h5);
    wr(4'h2, 8'h02);
    chk({7'h0, rej}, 8'h00);
    wr(4'h3, 8'h03);
    chk({7'h0, rej}, 8'h00);
    wr(4'h4, 8'h03);
    chk({7'h0, rej}, 8'h00);
    wr(4'h2, 8'h05);
    wr(4'h3, 8'h00);
    nums(3'h2, 3'h3, 3'h3);
    pc(3'h1, 3'h1, 3'h1);
    for (i = 2; i < 5; i = i + 1)
    begin
      wr(i[3:0], 8'h03);
      chk({7'h0, rej}, 8'h01);
    end
    nums(3'h1, 3'h1, 3'h1);
    rd(4'h2, rdv);
    chk(rdv, 8'h01);
    // Read data must drop back once its one cycle is over
    @(negedge sys_clk);
    chk(reg_rdata, 8'h00);
    rd(4'h5, rdv);
    chk(rdv, 8'h07);
    rd(4'h3, rdv);
    chk(rdv, 8'h01);
    $display("test method one done");
    wr(4'h1, 8'hfe);
    rd(4'h1, rdv);
    chk(rdv, 8'hfe);
    pc(3'h3, 3'h0, 3'h0);
    // Preset code 110 with its top bit unassigned decodes as 2
    pc(3'h1, 3'h0, 3'h6);
    nums(3'h2, 3'h1, 3'h2);
    wr(4'h1, 8'hff);
    wr(4'h0, 8'h07);
    rd(4'h0, rdv);
    chk(rdv, 8'h07);
    for (i = 0; i < 8; i = i + 1)
    begin
      pc(i[2:0], i[2:0], i[2:0]);
      nums((i > 3) ? 3'h4 : i[2:0] + 3'h1,
           (i > 3) ? 3'h4 : i[2:0] + 3'h1,
           (i > 4) ? 3'h5 : i[2:0] + 3'h1);
    end
    pc(3'h0, 3'h0, 3'h0);
    for (i = 2; i < 5; i = i + 1)
    begin
      wr(i[3:0], 8'h03);
      chk({7'h0, rej}, 8'h01);
    end
    nums(3'h1, 3'h1, 3'h1);
    $display("test method two done");
    wr(4'h0, 8'h50);
    pc(3'h0, 3'h2, 3'h0);
    chk({5'h0, pid_number}, 8'h02);
    wr(4'h0, 8'h00);
    chk({5'h0, pid_number}, 8'h00);
    $display("test zone done");
    // Reset again mid-run: the group numbers fall back to 1, pid_number to 0
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge sys_clk);
    nums(3'h1, 3'h1, 3'h1);
    chk({5'h0, pid_number}, 8'h00);
    rd(4'h0, rdv);
    chk(rdv, 8'h00);
    $display("test second reset done");
    close_out;
  end
endmodule
